// >>> core/sqe_spi_core.sv
`timescale 1ns/1ps
`default_nettype none

module sqe_spi_core (
	// Clocks and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       link_clk,
	// Control bits
	input  wire logic       ctrl_wr,
	input  wire logic       ctrl_enable_in,
	input  wire logic       master_select,
	input  wire logic       clock_polarity,
	input  wire logic       clock_phase,
	input  wire logic [1:0] bit_rate_select,
	input  wire logic       mode_fault_enable,
	input  wire logic       error_irq_enable,
	// Data and status access
	input  wire logic       status_rd,
	input  wire logic       data_rd,
	input  wire logic       data_wr,
	input  wire logic [7:0] data_wr_byte,
	output logic      [7:0] rx_data,
	// Status
	output logic            module_enable,
	output logic            tx_empty_flag,
	output logic            rx_full_flag,
	output logic            overrun_flag,
	output logic            mode_fault_flag,
	output logic            error_irq,
	// Serial pins
	input  wire logic       serial_clock_pin_i,
	output logic            serial_clock_pin_o,
	output logic            serial_clock_pin_oe,
	input  wire logic       mosi_i,
	output logic            mosi_o,
	output logic            mosi_oe,
	input  wire logic       miso_i,
	output logic            miso_o,
	output logic            miso_oe,
	input  wire logic       ss_n_i
);

	sqe_pkg::sqe_mst_type mst_r;
	logic [sqe_pkg::SYNC_W-1:0] s1_r, s2_r, s3_r, filt_r, filt_q_r;
	logic [6:0] pre_r;
	logic [3:0] half_r;
	logic [7:0] sh_r, buf_r, rx_byte_r, l_sh_r, l_byte_r;
	logic [2:0] l_cnt_r, l_out_r;
	logic       en_r, te_r, rf_r, ovr_r, mode_fault_flag_r, rf_arm_r, ovr_arm_r, mode_fault_flag_arm_r;
	logic       ph_r, pend_r, smp_r, sck_r, sbusy_r, sgot_r, done_tgl_r, bit1_tgl_r;

	// Pin and crossing inputs: a change counts once stages two and three agree.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s1_r     <= sqe_pkg::SYNC_RST;
			s2_r     <= sqe_pkg::SYNC_RST;
			s3_r     <= sqe_pkg::SYNC_RST;
			filt_r   <= sqe_pkg::SYNC_RST;
			filt_q_r <= sqe_pkg::SYNC_RST;
		end else begin
			s1_r     <= {bit1_tgl_r, done_tgl_r, serial_clock_pin_i, ss_n_i, miso_i};
			s2_r     <= s1_r;
			s3_r     <= s2_r;
			filt_r   <= (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
			filt_q_r <= filt_r;
		end
	end

	logic ss_f, ss_rise, ss_fall, done_evt, bit1_evt, sck_idle;
	assign ss_f     = filt_r[sqe_pkg::SI_SS];
	assign ss_rise  = ss_f & ~filt_q_r[sqe_pkg::SI_SS];
	assign ss_fall  = ~ss_f & filt_q_r[sqe_pkg::SI_SS];
	assign done_evt = filt_r[sqe_pkg::SI_DONE] ^ filt_q_r[sqe_pkg::SI_DONE];
	assign bit1_evt = filt_r[sqe_pkg::SI_BIT1] ^ filt_q_r[sqe_pkg::SI_BIT1];
	assign sck_idle = filt_r[sqe_pkg::SI_SCK] == clock_polarity;

	logic mst_on, slv_on, mst_cond, slv_cond, fault_now, mf_set_m, mode_fault_flag_set;
	assign mst_on    = en_r & master_select;
	assign slv_on    = en_r & ~master_select;
	assign mst_cond  = mst_on & ~ss_f;
	assign slv_cond  = slv_on & sbusy_r & ss_rise;
	assign fault_now = mst_cond | slv_cond;
	assign mode_fault_flag_set  = mode_fault_enable & fault_now;
	assign mf_set_m  = mode_fault_enable & mst_cond;

	// Bit-rate divider: ticks every half bit, ph_r marks bit boundaries.
	logic tick;
	assign tick = mst_on && (pre_r == sqe_pkg::half_of(bit_rate_select) - sqe_pkg::PRE_STEP);

	always_ff @(posedge clk_sys) begin
		if (rst || !mst_on) begin
			pre_r <= sqe_pkg::PRE_RST;
			ph_r  <= 1'b0;
		end else if (tick) begin
			pre_r <= sqe_pkg::PRE_RST;
			ph_r  <= ~ph_r;
		end else begin
			pre_r <= pre_r + sqe_pkg::PRE_STEP;
		end
	end

	logic run, start, mst_end, chain, mst_load, slv_load, load;
	assign run      = mst_r == sqe_pkg::MST_RUN;
	assign start    = pend_r && tick && ph_r && !run;
	assign mst_end  = run && tick && half_r == sqe_pkg::HALF_LAST;
	assign chain    = mst_end && !te_r;
	assign mst_load = mst_on && ((!run && !pend_r && !te_r) || chain);
	assign slv_load = slv_on && !sbusy_r && !te_r;
	assign load     = mst_load || slv_load;

	// Master sequencer: 16 half-bit steps per byte.
	always_ff @(posedge clk_sys) begin
		if (rst || !en_r || mf_set_m) begin
			mst_r  <= sqe_pkg::MST_IDLE;
			half_r <= sqe_pkg::HALF_FIRST;
			pend_r <= 1'b0;
			sck_r  <= clock_polarity;
		end else begin
			if (mst_load && !chain) begin
				pend_r <= 1'b1;
			end else if (start) begin
				pend_r <= 1'b0;
			end
			unique case (mst_r)
				sqe_pkg::MST_IDLE: begin
					if (start) begin
						mst_r  <= sqe_pkg::MST_RUN;
						half_r <= sqe_pkg::HALF_FIRST;
						sck_r  <= clock_polarity ^ clock_phase;
					end
				end
				sqe_pkg::MST_RUN: begin
					if (tick && half_r == sqe_pkg::HALF_LAST) begin
						half_r <= sqe_pkg::HALF_FIRST;
						if (chain) begin
							sck_r <= clock_polarity ^ clock_phase;
						end else begin
							mst_r <= sqe_pkg::MST_IDLE;
							sck_r <= clock_polarity;
						end
					end else if (tick) begin
						half_r <= half_r + sqe_pkg::HALF_STEP;
						sck_r  <= clock_polarity ^ clock_phase ^ ~half_r[0];
					end
				end
			endcase
		end
	end

	// Shared shift register; it keeps its value when nothing new is queued.
	always_ff @(posedge clk_sys) begin
		if (rst || !en_r) begin
			sh_r  <= sqe_pkg::BYTE_RST;
			smp_r <= 1'b0;
		end else if (load) begin
			sh_r <= buf_r;
		end else if (run && tick && !half_r[0]) begin
			smp_r <= filt_r[sqe_pkg::SI_MISO];
		end else if (run && tick && half_r[0]) begin
			sh_r <= {sh_r[6:0], smp_r};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			buf_r <= sqe_pkg::BYTE_RST;
		end else if (data_wr) begin
			buf_r <= data_wr_byte;
		end
	end

	// Slave transfer window as seen from the bus clock.
	always_ff @(posedge clk_sys) begin
		if (rst || !slv_on) begin
			sbusy_r <= 1'b0;
			sgot_r  <= 1'b0;
		end else if (!sbusy_r) begin
			sgot_r <= 1'b0;
			if (clock_phase ? (!ss_f && !sck_idle) : ss_fall) begin
				sbusy_r <= 1'b1;
			end
		end else begin
			if (done_evt) begin
				sgot_r <= 1'b1;
			end
			if ((sgot_r && sck_idle) || ss_f) begin
				sbusy_r <= 1'b0;
			end
		end
	end

	// Receive path and overrun.
	logic rx_evt, rx_load, bit1_hit;
	logic [7:0] rx_in;
	assign rx_evt   = mst_end || (slv_on && done_evt);
	assign rx_in    = master_select ? {sh_r[6:0], smp_r} : l_byte_r;
	assign rx_load  = rx_evt && !ovr_r;
	assign bit1_hit = (run && tick && half_r == sqe_pkg::HALF_BIT1) || (slv_on && bit1_evt);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rx_byte_r <= sqe_pkg::BYTE_RST;
		end else if (rx_load) begin
			rx_byte_r <= rx_in;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			en_r <= 1'b0;
		end else if (mf_set_m) begin
			en_r <= 1'b0;
		end else if (ctrl_wr) begin
			en_r <= ctrl_enable_in;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			te_r <= 1'b1;
		end else if (!en_r || mf_set_m || load) begin
			te_r <= 1'b1;
		end else if (data_wr) begin
			te_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rf_r     <= 1'b0;
			rf_arm_r <= 1'b0;
		end else begin
			rf_r <= rx_load || (rf_r && !(rf_arm_r && data_rd));
			if (data_rd) begin
				rf_arm_r <= 1'b0;
			end else if (status_rd && rf_r) begin
				rf_arm_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ovr_r     <= 1'b0;
			ovr_arm_r <= 1'b0;
		end else begin
			ovr_r <= (bit1_hit && rf_r) || (ovr_r && !(ovr_arm_r && data_rd));
			if (data_rd) begin
				ovr_arm_r <= 1'b0;
			end else if (status_rd && ovr_r) begin
				ovr_arm_r <= 1'b1;
			end
		end
	end

	// A fault anywhere in the clearing sequence spoils it.
	// A low select in master mode stays a fault after the enable drops, so it still blocks the clear.
	logic mode_fault_flag_block;
	assign mode_fault_flag_block = fault_now || (master_select && !ss_f);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mode_fault_flag_r     <= 1'b0;
			mode_fault_flag_arm_r <= 1'b0;
		end else begin
			mode_fault_flag_r <= mode_fault_flag_set || (mode_fault_flag_r && !(mode_fault_flag_arm_r && ctrl_wr && !mode_fault_flag_block));
			if (mode_fault_flag_block || ctrl_wr) begin
				mode_fault_flag_arm_r <= 1'b0;
			end else if (status_rd && mode_fault_flag_r) begin
				mode_fault_flag_arm_r <= 1'b1;
			end
		end
	end

	// Link side: the remote master clock, re-oriented so its sample edge is a rising edge.
	// Polarity and phase must only change while disabled, as they steer this clock.
	logic slv_clk, slv_rst;
	assign slv_clk = link_clk ^ (clock_polarity ^ clock_phase);
	assign slv_rst = ss_n_i || !slv_on;

	always_ff @(posedge slv_clk or posedge slv_rst) begin
		if (slv_rst) begin
			l_cnt_r <= sqe_pkg::SMP_FIRST;
			l_sh_r  <= sqe_pkg::BYTE_RST;
		end else begin
			l_cnt_r <= l_cnt_r + sqe_pkg::SMP_STEP;
			l_sh_r  <= {l_sh_r[6:0], mosi_i};
		end
	end

	// Toggles and the received byte survive deselect so the bus side never sees a false event.
	always_ff @(posedge slv_clk or posedge rst) begin
		if (rst) begin
			done_tgl_r <= 1'b0;
			bit1_tgl_r <= 1'b0;
			l_byte_r   <= sqe_pkg::BYTE_RST;
		end else if (!slv_rst) begin
			if (l_cnt_r == sqe_pkg::SMP_BIT1) begin
				bit1_tgl_r <= ~bit1_tgl_r;
			end
			if (l_cnt_r == sqe_pkg::SMP_LAST) begin
				done_tgl_r <= ~done_tgl_r;
				l_byte_r   <= {l_sh_r[6:0], mosi_i};
			end
		end
	end

	always_ff @(negedge slv_clk or posedge slv_rst) begin
		if (slv_rst) begin
			l_out_r <= sqe_pkg::SMP_FIRST;
		end else begin
			l_out_r <= l_out_r + sqe_pkg::SMP_STEP;
		end
	end

	logic [2:0] out_idx;
	assign out_idx = l_out_r - {2'b00, clock_phase};

	// Pin drive follows the mode; a disabled block leaves the pins to the port.
	assign serial_clock_pin_o  = sck_r;
	assign serial_clock_pin_oe = mst_on;
	assign mosi_o              = sh_r[7];
	assign mosi_oe             = mst_on;
	assign miso_o              = sh_r[~out_idx];
	assign miso_oe             = slv_on && !ss_n_i;

	assign rx_data         = rx_byte_r;
	assign module_enable   = en_r;
	assign tx_empty_flag   = te_r;
	assign rx_full_flag    = rf_r;
	assign overrun_flag    = ovr_r;
	assign mode_fault_flag = mode_fault_flag_r;
	assign error_irq       = error_irq_enable && (ovr_r || mode_fault_flag_r);

	property p_write_clears_te;
		@(posedge clk_sys) disable iff (rst)
		data_wr && en_r && te_r && !mf_set_m |=> !te_r;
	endproperty
	a_write_clears_te: assert property (p_write_clears_te) else $error("write did not clear tx empty");

	property p_te_returns;
		@(posedge clk_sys) disable iff (rst)
		$fell(te_r) && (master_select ? (!run && !pend_r) : !sbusy_r) |-> ##[1:2] (te_r || !en_r);
	endproperty
	a_te_returns: assert property (p_te_returns) else $error("tx empty not set within two cycles");

	property p_start_delay;
		@(posedge clk_sys) disable iff (rst)
		$rose(pend_r) |-> ##[1:128] (run || !en_r);
	endproperty
	a_start_delay: assert property (p_start_delay) else $error("master start exceeded one bit time");

	property p_div_gated;
		@(posedge clk_sys) disable iff (rst)
		!mst_on |=> pre_r == sqe_pkg::PRE_RST && !tick;
	endproperty
	a_div_gated: assert property (p_div_gated) else $error("divider ran while not master");

	property p_ovr_holds_data;
		@(posedge clk_sys) disable iff (rst)
		ovr_r && rx_evt |=> $stable(rx_byte_r) && rf_r == $past(rf_r && !(rf_arm_r && data_rd));
	endproperty
	a_ovr_holds_data: assert property (p_ovr_holds_data) else $error("byte loaded during overrun");

	property p_mode_fault_flag_gated;
		@(posedge clk_sys) disable iff (rst)
		!mode_fault_enable && !mode_fault_flag_r |=> !mode_fault_flag_r;
	endproperty
	a_mode_fault_flag_gated: assert property (p_mode_fault_flag_gated) else $error("mode fault set while disabled");

	property p_master_fault;
		@(posedge clk_sys) disable iff (rst)
		mf_set_m |=> !en_r && te_r && !run && !serial_clock_pin_oe && mode_fault_flag_r;
	endproperty
	a_master_fault: assert property (p_master_fault) else $error("master fault effects missing");

	property p_deselect_float;
		@(posedge clk_sys) disable iff (rst)
		ss_n_i && !master_select |-> !miso_oe;
	endproperty
	a_deselect_float: assert property (p_deselect_float) else $error("MISO driven while deselected");

	property p_rf_clear;
		@(posedge clk_sys) disable iff (rst)
		rf_arm_r && data_rd && !rx_load |=> !rf_r;
	endproperty
	a_rf_clear: assert property (p_rf_clear) else $error("receive full not cleared");

	property p_ovr_set;
		@(posedge clk_sys) disable iff (rst)
		bit1_hit && rf_r |=> ovr_r;
	endproperty
	a_ovr_set: assert property (p_ovr_set) else $error("overrun missed at bit 1 strobe");

	property p_first_half;
		@(posedge clk_sys) disable iff (rst)
		start && !mf_set_m |=> run && serial_clock_pin_o == (clock_polarity ^ clock_phase);
	endproperty
	a_first_half: assert property (p_first_half) else $error("wrong clock level at first half bit");

endmodule

`default_nettype wire

// >>> core/sqe_pkg.sv
package sqe_pkg;

	// Master sequencer states.
	typedef enum logic [1:0] {
		MST_IDLE = 2'b01,
		MST_RUN  = 2'b10
	} sqe_mst_type;

	// Bit rate select codes.
	localparam logic [1:0] RATE_DIVIDE_BY_TWO   = 2'h0;
	localparam logic [1:0] RATE_DIV8   = 2'h1;
	localparam logic [1:0] RATE_DIVIDE_BY_THIRTY_TWO  = 2'h2;
	localparam logic [1:0] RATE_DIVIDE_BY_ONE_TWENTY_EIGHT = 2'h3;

	// Half a bit time in bus cycles for each rate.
	localparam logic [6:0] HALF_DIVIDE_BY_TWO   = 7'h01;
	localparam logic [6:0] HALF_DIV8   = 7'h04;
	localparam logic [6:0] HALF_DIVIDE_BY_THIRTY_TWO  = 7'h10;
	localparam logic [6:0] HALF_DIVIDE_BY_ONE_TWENTY_EIGHT = 7'h40;

	// Half-period positions inside one byte: 16 halves, bit 1 sampled on the 7th sample.
	localparam logic [3:0] HALF_FIRST = 4'h0;
	localparam logic [3:0] HALF_BIT1  = 4'hC;
	localparam logic [3:0] HALF_LAST  = 4'hF;

	// Sample counts on the link side.
	localparam logic [2:0] SMP_FIRST = 3'h0;
	localparam logic [2:0] SMP_BIT1  = 3'h6;
	localparam logic [2:0] SMP_LAST  = 3'h7;

	// Synchroniser lanes.
	localparam int SYNC_W  = 5;
	localparam int SI_MISO = 0;
	localparam int SI_SS   = 1;
	localparam int SI_SCK  = 2;
	localparam int SI_DONE = 3;
	localparam int SI_BIT1 = 4;
	localparam logic [4:0] SYNC_RST = 5'h02;

	localparam logic [7:0] BYTE_RST  = 8'h00;
	localparam logic [6:0] PRE_RST   = 7'h00;
	localparam logic [6:0] PRE_STEP  = 7'h01;
	localparam logic [3:0] HALF_STEP = 4'h1;
	localparam logic [2:0] SMP_STEP  = 3'h1;

	function automatic logic [6:0] half_of(input logic [1:0] rate);
		logic [6:0] h;
		h = HALF_DIVIDE_BY_TWO;
		case (rate)
			RATE_DIVIDE_BY_TWO:   h = HALF_DIVIDE_BY_TWO;
			RATE_DIV8:   h = HALF_DIV8;
			RATE_DIVIDE_BY_THIRTY_TWO:  h = HALF_DIVIDE_BY_THIRTY_TWO;
			RATE_DIVIDE_BY_ONE_TWENTY_EIGHT: h = HALF_DIVIDE_BY_ONE_TWENTY_EIGHT;
			default:     h = HALF_DIVIDE_BY_TWO;
		endcase
		return h;
	endfunction

endpackage

// >>> dv/sqe_far_end.sv
`timescale 1ns/1ps
`default_nettype none

// Remote SPI party: a clock-phase-0 slave when the block is master, a
// clock-phase-1 master at a 32 ns bit period when the block is slave.
module sqe_far_end (
	// Mode
	input  wire logic       as_master,
	// Serial pins
	input  wire logic       sck_i,
	input  wire logic       mosi_i,
	input  wire logic       miso_i,
	output logic            sck_o,
	output logic            mosi_o,
	output logic            miso_o,
	// Received byte
	output logic            got_stb,
	output logic [7:0]      got_byte
);
	logic [7:0] sh  = 8'h00;
	logic [7:0] nxt = 8'h00;
	logic [7:0] rx  = 8'h00;
	logic [3:0] cnt = 4'h0;

	initial begin
		sck_o = 1'b0;
		mosi_o = 1'b0;
		got_stb = 1'b0;
		got_byte = 8'h00;
	end

	// The slave drives its shifter MSB at all times, so a stale bit never lingers.
	assign miso_o = sh[7];

	always @(posedge sck_i) begin
		if (!as_master) begin
			rx = {rx[6:0], mosi_i};
			cnt = cnt + 4'h1;
			if (cnt == 4'h8) begin
				cnt = 4'h0;
				got_byte = rx;
				got_stb = 1'b1;
				#1 got_stb = 1'b0;
			end
		end
	end

	// After a whole byte the next one is loaded; otherwise the shifter moves on.
	always @(negedge sck_i) begin
		if (!as_master) begin
			sh = (cnt == 4'h0) ? nxt : {sh[6:0], ~sh[7]};
		end
	end

	task automatic xfer(input logic [7:0] b, input int nbits);
		int i;
		for (i = 0; i < nbits; i++) begin
			mosi_o = b[7-i];
			sck_o = 1'b1;
			#16;
			rx = {rx[6:0], miso_i};
			sck_o = 1'b0;
			#16;
		end
		mosi_o = ~mosi_o;
		if (nbits == 8) begin
			got_byte = rx;
			got_stb = 1'b1;
			#1 got_stb = 1'b0;
		end
	endtask
endmodule

`default_nettype wire

// >>> dv/tb_sqe_spi_core.sv
`timescale 1ns/1ps
`default_nettype none

module tb_sqe_spi_core;
	logic       clk_sys = 1'b0;
	logic       rst = 1'b1;
	logic       ctrl_wr = 1'b0;
	logic       ctrl_enable_in = 1'b0;
	logic       master_select = 1'b1;
	logic       clock_phase = 1'b0;
	logic [1:0] bit_rate_select = sqe_pkg::RATE_DIVIDE_BY_THIRTY_TWO;
	logic       mode_fault_enable = 1'b0;
	logic       error_irq_enable = 1'b1;
	logic       status_rd = 1'b0;
	logic       data_rd = 1'b0;
	logic       data_wr = 1'b0;
	logic [7:0] data_wr_byte = 8'h00;
	logic       ss_n = 1'b1;
	logic       as_master = 1'b0;
	logic [7:0] rx_data;
	logic       module_enable, tx_empty_flag, rx_full_flag, overrun_flag, mode_fault_flag, error_irq;
	logic       sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
	logic       far_sck, far_mosi, far_miso, far_got;
	logic [7:0] far_byte;
	logic [7:0] exp_q[$];
	logic [7:0] far_q[$];
	logic [7:0] r0, r1, t0, t1, m0;
	int         n_errors = 0;
	int         checks = 0;
	wire        sck_w  = sck_oe ? sck_o : far_sck;
	wire        mosi_w = mosi_oe ? mosi_o : far_mosi;
	wire        miso_w = miso_oe ? miso_o : far_miso;

	always #2 clk_sys = ~clk_sys;

	sqe_spi_core i_dut (.clk_sys(clk_sys), .rst(rst), .link_clk(sck_w), .ctrl_wr(ctrl_wr),
		.ctrl_enable_in(ctrl_enable_in), .master_select(master_select), .clock_polarity(1'b0),
		.clock_phase(clock_phase), .bit_rate_select(bit_rate_select), .mode_fault_enable(mode_fault_enable),
		.error_irq_enable(error_irq_enable), .status_rd(status_rd), .data_rd(data_rd), .data_wr(data_wr),
		.data_wr_byte(data_wr_byte), .rx_data(rx_data), .module_enable(module_enable),
		.tx_empty_flag(tx_empty_flag), .rx_full_flag(rx_full_flag), .overrun_flag(overrun_flag),
		.mode_fault_flag(mode_fault_flag), .error_irq(error_irq), .serial_clock_pin_i(sck_w),
		.serial_clock_pin_o(sck_o), .serial_clock_pin_oe(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o),
		.mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_n));

	sqe_far_end i_far (.as_master(as_master), .sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w),
		.sck_o(far_sck), .mosi_o(far_mosi), .miso_o(far_miso), .got_stb(far_got), .got_byte(far_byte));

	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Status word: irq, sck oe, mosi oe, miso oe, enable, tx empty, rx full, overrun, mode fault.
	function automatic logic [8:0] st();
		return {error_irq, sck_oe, mosi_oe, miso_oe, module_enable, tx_empty_flag, rx_full_flag,
			overrun_flag, mode_fault_flag};
	endfunction

	task automatic give_verdict();
		if (n_errors == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Strobe kinds: 0 data write, 1 data read, 2 status read, 3 control write (b[0] is enable).
	task automatic strobe(input int k, input logic [7:0] b);
		@(posedge clk_sys);
		#1;
		data_wr_byte = b;
		ctrl_enable_in = b[0];
		case (k)
			0: data_wr = 1'b1;
			1: data_rd = 1'b1;
			2: status_rd = 1'b1;
			default: ctrl_wr = 1'b1;
		endcase
		@(posedge clk_sys);
		#1;
		data_wr = 1'b0;
		data_rd = 1'b0;
		status_rd = 1'b0;
		ctrl_wr = 1'b0;
	endtask

	task automatic wait_hi(ref logic s, input int lim);
		int i;
		for (i = 0; i < lim && s !== 1'b1; i++) begin
			@(posedge clk_sys);
			#1;
		end
		check("wait", {8'h00, s}, 9'h001);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	always @(posedge rx_full_flag) begin
		#1;
		check("rx_data", {1'b0, rx_data}, {1'b0, exp_q.pop_front()});
	end

	always @(posedge far_got) begin
		#1;
		check("far_byte", {1'b0, far_byte}, {1'b0, far_q.pop_front()});
	end

	initial begin
		#100000;
		n_errors++;
		give_verdict();
	end

	initial begin
		void'($urandom(63));
		settle(10);
		rst = 1'b0;
		settle(4);
		check("reset", st(), 9'h008);
		// Master: two bytes back to back, receive register left unread.
		{r0, r1, t0, t1} = $urandom;
		i_far.sh = r0;
		i_far.nxt = r1;
		strobe(3, 8'h01);
		check("master_pins", st(), 9'h0D8);
		exp_q.push_back(r0);
		far_q.push_back(t0);
		far_q.push_back(t1);
		strobe(0, t0);
		check("tx_taken", st(), 9'h0D0);
		settle(1);
		check("tx_moved", st(), 9'h0D8);
		wait_hi(sck_o, 50);
		strobe(0, t1);
		check("queued", st(), 9'h0D0);
		wait_hi(overrun_flag, 600);
		settle(80);
		check("overrun", st(), 9'h1DE);
		check("kept", {1'b0, rx_data}, {1'b0, r0});
		strobe(2, 8'h00);
		strobe(1, 8'h00);
		settle(1);
		check("ovr_clear", st(), 9'h0D8);
		// Master mode fault with select low.
		mode_fault_enable = 1'b1;
		ss_n = 1'b0;
		settle(6);
		check("mst_fault", st(), 9'h109);
		strobe(2, 8'h00);
		strobe(3, 8'h00);
		settle(1);
		check("fault_held", st(), 9'h109);
		ss_n = 1'b1;
		settle(6);
		strobe(2, 8'h00);
		strobe(3, 8'h00);
		settle(1);
		check("fault_clear", st(), 9'h008);
		mode_fault_enable = 1'b0;
		strobe(3, 8'h01);
		ss_n = 1'b0;
		settle(6);
		check("fault_gated", st(), 9'h0D8);
		ss_n = 1'b1;
		strobe(3, 8'h00);
		// Slave: phase 1 byte from the far master, then an aborted frame.
		master_select = 1'b0;
		clock_phase = 1'b1;
		as_master = 1'b1;
		settle(6);
		strobe(3, 8'h01);
		check("slave_idle", st(), 9'h018);
		m0 = 8'($urandom);
		exp_q.push_back(m0);
		far_q.push_back(t0 ^ 8'h5A);
		strobe(0, t0 ^ 8'h5A);
		settle(2);
		check("slave_tx", st(), 9'h018);
		ss_n = 1'b0;
		settle(6);
		check("slave_sel", st(), 9'h038);
		#7;
		i_far.xfer(m0, 8);
		settle(14);
		check("slave_rx", st(), 9'h03C);
		strobe(2, 8'h00);
		strobe(1, 8'h00);
		mode_fault_enable = 1'b1;
		i_far.xfer(8'hC3, 3);
		ss_n = 1'b1;
		settle(10);
		check("slv_fault", st(), 9'h119);
		check("leftover", 9'(exp_q.size() + far_q.size()), 9'h000);
		give_verdict();
	end
endmodule

`default_nettype wire
